// >>> include/frb_pkg.sv
// Package of constants for the flash rewrite and boot mode control block
`default_nettype none
package frb_pkg;
   // Rewrite modes
   typedef enum logic [1:0] {
      FRB_MODE_CPU,
      FRB_MODE_SERIAL,
      FRB_MODE_PARALLEL,
      FRB_MODE_CAN
   } frb_mode_e;

   // Software commands, eight in all
   typedef enum logic [2:0] {
      FRB_CMD_READ_ARRAY,
      FRB_CMD_READ_STATUS,
      FRB_CMD_CLEAR_STATUS,
      FRB_CMD_PROGRAM,
      FRB_CMD_BLOCK_ERASE,
      FRB_CMD_ERASE_ALL,
      FRB_CMD_LOCK_PROGRAM,
      FRB_CMD_READ_LOCK
   } frb_cmd_e;

   // Register offsets
   localparam logic [3:0] FRB_OFS_FLASH_CTRL0 = 4'h0;
   localparam logic [3:0] FRB_OFS_PROC_MODE1  = 4'h1;
   localparam logic [3:0] FRB_OFS_COMMAND     = 4'h2;
   localparam logic [3:0] FRB_OFS_STATUS      = 4'h3;
   localparam logic [3:0] FRB_OFS_LOCK        = 4'h4;
   localparam logic [3:0] FRB_OFS_MODE        = 4'h5;

   // Flash control register zero bit positions
   localparam int FRB_BIT_READY       = 0;
   localparam int FRB_BIT_REWRITE_EN  = 1;
   localparam int FRB_BIT_ROM_SEL     = 5;
   localparam int FRB_BIT_PROG_ERR    = 6;
   localparam int FRB_BIT_ERASE_ERR   = 7;

   // Processor mode register one bit positions
   localparam int FRB_BIT_BLOCK_A     = 0;
   localparam int FRB_BIT_EXPAND      = 3;

   // Command register fields
   localparam int FRB_CMD_LSB         = 0;
   localparam int FRB_BLK_LSB         = 4;
   localparam int FRB_BYTE_BIT        = 8;

   // Reset values
   localparam logic [7:0] FRB_RST_FLASH_CTRL0 = 8'h01;
   localparam logic [7:0] FRB_RST_PROC_MODE1  = 8'h00;

   // Block A region and size
   localparam logic [19:0] FRB_BLOCK_A_LO     = 20'h10000;
   localparam logic [19:0] FRB_BLOCK_A_HI     = 20'h26FFF;
   localparam int          FRB_BLOCK_A_BYTES  = 4096;

   // Busy time of an operation in ns and its cycle count
   localparam int FRB_CLK_PERIOD_NS = 10;
   localparam int FRB_OP_TIME_NS    = 200;
   localparam int FRB_OP_CYCLES     = (FRB_OP_TIME_NS + FRB_CLK_PERIOD_NS - 1) / FRB_CLK_PERIOD_NS;
endpackage
`default_nettype wire

// >>> rtl/frb_flash_ctrl.sv
// Flash rewrite mode, ROM area and boot mode control
//
// How it works
// R1: Four rewrite modes: CPU, standard serial, parallel, CAN.
// R2: User ROM has a separate 4 Kbyte block A.
// R3: Block A and region 10000h-26FFFh enabled only when block-A bit is 1.
// R4: Word programming always; byte programming only in parallel mode.
// R5: Erase all blocks together, or one chosen block.
// R6: Each block has a lock bit preventing program and erase; the erase-all command here ignores the lock bits.
// R7: Program and erase start only through eight software commands.
// R8: Boot ROM rewritable only in parallel mode; user ROM in all.
// R9: Reset with mode pin high, strap A high, strap B low enters boot.
// R10: Reset with mode pin low starts from user ROM.
// R11: Boot ROM shares user ROM addresses and is not readable.
// R12: In boot mode the ROM select bit picks boot or user ROM.
// R13: CPU rewrite forces block-A and expansion bits to 1.
// R14: Expansion bit held 1 in rewrite; written value applies after exit.
// R15: Rewrite software runs from RAM or expansion area only.
// R16: CPU rewrite in single chip; expansion and boot modes erase-write zero only.
// R17: Serial sub-mode one uses programmer-clocked synchronous serial.
// R18: Serial sub-mode two needs 5, 10 or 16 MHz main clock.
// R19: Each block should be erased at most 100 times.
// R20: ROM select 0 gives boot ROM, 1 user ROM, only in boot mode.
// R21: Rewrite enable set by writing 0 then 1 in succession.
// R22: Straps sampled at reset release and held until next reset.
`timescale 1ns/1ps
`default_nettype none
module frb_flash_ctrl #(
   parameter int NUM_BLOCKS = 8,
   parameter int DATA_W     = 16
) (
   input  wire logic              clock,
   input  wire logic              reset_n,
   input  wire logic              processor_mode_pin,
   input  wire logic              boot_strap_high_pin,
   input  wire logic              boot_strap_low_pin,
   input  wire logic              memory_expansion_mode,
   input  wire logic              ew_variant_one,
   input  wire logic [1:0]        rewrite_mode,
   input  wire logic [19:0]       cpu_addr,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [DATA_W-1:0] reg_rdata,
   output logic                   boot_mode,
   output logic                   boot_rom_selected,
   output logic                   block_a_selected,
   output logic                   flash_busy,
   output logic                   program_pulse,
   output logic                   erase_pulse
);
   // ------------------------------------------------------------
   // Strap synchronisers and reset sampling
   // ------------------------------------------------------------
   logic [2:0] strap_meta_q;
   logic [2:0] strap_sync_q;
   logic       straps_taken_q;
   logic       boot_mode_q;
   logic       boot_mode_d;

   always_ff @(posedge clock) begin
      strap_meta_q <= {processor_mode_pin, boot_strap_high_pin, boot_strap_low_pin};
      strap_sync_q <= strap_meta_q;
   end

   // Boot entry needs mode pin high, strap A high, strap B low
   assign boot_mode_d = strap_sync_q[2] & strap_sync_q[1] & ~strap_sync_q[0]; // [R9] [R10]

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         straps_taken_q <= 1'b0;
         boot_mode_q    <= 1'b0;
      end else if (!straps_taken_q) begin
         straps_taken_q <= 1'b1;
         boot_mode_q    <= boot_mode_d; // [R22]
      end
   end

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   wire wr_fc0  = reg_write && reg_addr == frb_pkg::FRB_OFS_FLASH_CTRL0;
   wire wr_pm1  = reg_write && reg_addr == frb_pkg::FRB_OFS_PROC_MODE1;
   wire wr_cmd  = reg_write && reg_addr == frb_pkg::FRB_OFS_COMMAND;
   wire wr_stat = reg_write && reg_addr == frb_pkg::FRB_OFS_STATUS;
   wire wr_lock = reg_write && reg_addr == frb_pkg::FRB_OFS_LOCK;

   // ------------------------------------------------------------
   // Flash control register zero
   // ------------------------------------------------------------
   logic rewrite_en_q;
   logic rewrite_armed_q;
   logic rom_sel_q;
   logic prog_err_q;
   logic erase_err_q;

   wire wr_en_bit  = reg_wdata[frb_pkg::FRB_BIT_REWRITE_EN];
   wire parallel_m = rewrite_mode == 2'(frb_pkg::FRB_MODE_PARALLEL);
   wire cpu_m      = rewrite_mode == 2'(frb_pkg::FRB_MODE_CPU);
   // Variant one of CPU rewrite is only allowed in single-chip, non-boot operation
   wire cpu_ok     = cpu_m && !(ew_variant_one && (memory_expansion_mode || boot_mode_q)); // [R16]
   // Serial and CAN rewrite run only in boot mode
   wire mode_ok    = cpu_m ? cpu_ok : (parallel_m || boot_mode_q); // [R1] [R16] [R17]

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rewrite_en_q    <= frb_pkg::FRB_RST_FLASH_CTRL0[frb_pkg::FRB_BIT_REWRITE_EN];
         rewrite_armed_q <= 1'b0;
         rom_sel_q       <= frb_pkg::FRB_RST_FLASH_CTRL0[frb_pkg::FRB_BIT_ROM_SEL];
      end else if (wr_fc0) begin
         // Enable needs a 0 write directly followed by a 1 write
         rewrite_armed_q <= !wr_en_bit; // [R21]
         rewrite_en_q    <= wr_en_bit && (rewrite_armed_q || rewrite_en_q) && cpu_ok; // [R21]
         rom_sel_q       <= reg_wdata[frb_pkg::FRB_BIT_ROM_SEL];
      end else if (reg_write) begin
         rewrite_armed_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Processor mode register one
   // ------------------------------------------------------------
   logic block_a_q;
   logic expand_q;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         block_a_q <= frb_pkg::FRB_RST_PROC_MODE1[frb_pkg::FRB_BIT_BLOCK_A];
         expand_q  <= frb_pkg::FRB_RST_PROC_MODE1[frb_pkg::FRB_BIT_EXPAND];
      end else if (wr_pm1) begin
         block_a_q <= reg_wdata[frb_pkg::FRB_BIT_BLOCK_A];
         expand_q  <= reg_wdata[frb_pkg::FRB_BIT_EXPAND]; // [R14]
      end
   end

   // Stored value shows again once rewrite ends
   wire block_a_eff = block_a_q | rewrite_en_q; // [R13]
   wire expand_eff  = expand_q | rewrite_en_q;  // [R13] [R14]

   // ------------------------------------------------------------
   // Address routing
   // ------------------------------------------------------------
   wire in_block_a = cpu_addr >= frb_pkg::FRB_BLOCK_A_LO && cpu_addr <= frb_pkg::FRB_BLOCK_A_HI;
   // Boot ROM overlays user ROM; select only counts in boot mode
   wire boot_route = boot_mode_q && !rom_sel_q; // [R11] [R12] [R20]

   // ------------------------------------------------------------
   // Lock bits and command engine
   // ------------------------------------------------------------
   localparam int BW = $clog2(NUM_BLOCKS);
   localparam int CW = $clog2(frb_pkg::FRB_OP_CYCLES + 1);

   logic [NUM_BLOCKS-1:0] lock_q;
   logic [CW-1:0]         busy_cnt_q;
   logic                  prog_q;
   logic                  erase_q;

   wire [2:0]    cmd      = reg_wdata[frb_pkg::FRB_CMD_LSB +: 3];
   wire [BW-1:0] blk      = reg_wdata[frb_pkg::FRB_BLK_LSB +: BW];
   wire          byte_op  = reg_wdata[frb_pkg::FRB_BYTE_BIT];
   wire          idle     = busy_cnt_q == '0;
   // Boot ROM is only reachable by the parallel programmer
   wire          area_ok  = !boot_route || parallel_m; // [R8]
   wire          width_ok = !byte_op || parallel_m;    // [R4]
   wire          rights   = mode_ok && (!cpu_m || rewrite_en_q) && area_ok;
   wire          is_prog  = cmd == 3'(frb_pkg::FRB_CMD_PROGRAM);
   wire          is_berase = cmd == 3'(frb_pkg::FRB_CMD_BLOCK_ERASE);
   wire          is_eall  = cmd == 3'(frb_pkg::FRB_CMD_ERASE_ALL);
   wire          blk_lock = lock_q[blk];
   // Only the command register starts an operation
   wire          go_prog  = wr_cmd && idle && rights && is_prog && width_ok && !blk_lock;  // [R7] [R6] [R4]
   wire          go_erase = wr_cmd && idle && rights && ((is_berase && !blk_lock) || is_eall); // [R5] [R6] [R7]
   wire          bad_prog = wr_cmd && is_prog && !go_prog;
   wire          bad_erase = wr_cmd && (is_berase || is_eall) && !go_erase;
   wire          go_lock  = wr_cmd && idle && rights && cmd == 3'(frb_pkg::FRB_CMD_LOCK_PROGRAM);
   wire          clr_stat = wr_stat || (wr_cmd && cmd == 3'(frb_pkg::FRB_CMD_CLEAR_STATUS));

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         lock_q <= '0;
      end else if (go_lock) begin
         lock_q[blk] <= 1'b1; // [R6]
      end else if (wr_lock) begin
         lock_q <= lock_q & reg_wdata[NUM_BLOCKS-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         busy_cnt_q <= '0;
         prog_q     <= 1'b0;
         erase_q    <= 1'b0;
      end else begin
         prog_q  <= go_prog;
         erase_q <= go_erase;
         if (go_prog || go_erase) begin
            busy_cnt_q <= CW'(frb_pkg::FRB_OP_CYCLES);
         end else if (!idle) begin
            busy_cnt_q <= busy_cnt_q - 1'b1;
         end
      end
   end

   // Error flags: a new error wins over a clear in the same cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         prog_err_q  <= 1'b0;
         erase_err_q <= 1'b0;
      end else begin
         prog_err_q  <= bad_prog || (prog_err_q && !clr_stat);
         erase_err_q <= bad_erase || (erase_err_q && !clr_stat);
      end
   end

   // ------------------------------------------------------------
   // Read path and outputs
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (reg_addr)
         frb_pkg::FRB_OFS_FLASH_CTRL0: begin
            rd_mux[frb_pkg::FRB_BIT_READY]      = idle;
            rd_mux[frb_pkg::FRB_BIT_REWRITE_EN] = rewrite_en_q;
            rd_mux[frb_pkg::FRB_BIT_ROM_SEL]    = rom_sel_q;
            rd_mux[frb_pkg::FRB_BIT_PROG_ERR]   = prog_err_q;
            rd_mux[frb_pkg::FRB_BIT_ERASE_ERR]  = erase_err_q;
         end
         frb_pkg::FRB_OFS_PROC_MODE1: begin
            rd_mux[frb_pkg::FRB_BIT_BLOCK_A] = block_a_eff;
            rd_mux[frb_pkg::FRB_BIT_EXPAND]  = expand_eff;
         end
         frb_pkg::FRB_OFS_LOCK: begin
            rd_mux[NUM_BLOCKS-1:0] = lock_q;
         end
         frb_pkg::FRB_OFS_MODE: begin
            rd_mux[0] = boot_mode_q;
            rd_mux[1] = mode_ok;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         reg_rdata         <= '0;
         boot_mode         <= 1'b0;
         boot_rom_selected <= 1'b0;
         block_a_selected  <= 1'b0;
         flash_busy        <= 1'b0;
         program_pulse     <= 1'b0;
         erase_pulse       <= 1'b0;
      end else begin
         reg_rdata         <= reg_read ? rd_mux : '0;
         boot_mode         <= boot_mode_q;
         boot_rom_selected <= boot_route;                // [R12]
         block_a_selected  <= in_block_a && block_a_eff; // [R2] [R3]
         flash_busy        <= !idle;
         program_pulse     <= prog_q;
         erase_pulse       <= erase_q;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_block_a_gate: assert property (@(posedge clock) disable iff (!reset_n) // [R3]
      block_a_selected |-> $past(block_a_eff) && $past(in_block_a))
      else $error("block A selected while disabled");
   a_force_bits: assert property (@(posedge clock) disable iff (!reset_n) // [R13]
      rewrite_en_q && reg_read && reg_addr == frb_pkg::FRB_OFS_PROC_MODE1 |=>
         reg_rdata[frb_pkg::FRB_BIT_BLOCK_A] && reg_rdata[frb_pkg::FRB_BIT_EXPAND])
      else $error("rewrite did not force mode bits");
   a_expand_restore: assert property (@(posedge clock) disable iff (!reset_n) // [R14]
      !rewrite_en_q && reg_read && reg_addr == frb_pkg::FRB_OFS_PROC_MODE1 |=>
         reg_rdata[frb_pkg::FRB_BIT_EXPAND] == $past(expand_q))
      else $error("expansion bit not restored");
   a_enable_seq: assert property (@(posedge clock) disable iff (!reset_n) // [R21]
      $rose(rewrite_en_q) |-> $past(rewrite_armed_q))
      else $error("rewrite enabled without 0 then 1");
   a_byte_parallel: assert property (@(posedge clock) disable iff (!reset_n) // [R4]
      wr_cmd && is_prog && byte_op && !parallel_m |-> ##2 !program_pulse)
      else $error("byte program outside parallel mode");
   a_lock_blocks: assert property (@(posedge clock) disable iff (!reset_n) // [R6]
      wr_cmd && (is_prog || is_berase) && blk_lock |-> ##2 !program_pulse && !erase_pulse)
      else $error("locked block altered");
   a_boot_area: assert property (@(posedge clock) disable iff (!reset_n) // [R8]
      wr_cmd && boot_route && !parallel_m |-> ##2 !program_pulse && !erase_pulse)
      else $error("boot ROM rewritten outside parallel");
   a_boot_hold: assert property (@(posedge clock) disable iff (!reset_n) // [R22]
      straps_taken_q && $past(straps_taken_q) |-> $stable(boot_mode_q))
      else $error("boot selection changed");
   a_rom_select: assert property (@(posedge clock) disable iff (!reset_n) // [R20]
      !boot_mode_q |=> !boot_rom_selected)
      else $error("ROM select active outside boot");
   a_busy_span: assert property (@(posedge clock) disable iff (!reset_n) // [R7]
      go_prog |-> ##2 flash_busy [*3])
      else $error("busy not shown after program");
   c_prog: cover property (@(posedge clock) disable iff (!reset_n) go_prog);
   c_erase_all: cover property (@(posedge clock) disable iff (!reset_n) go_erase && is_eall);
   c_rewrite_on: cover property (@(posedge clock) disable iff (!reset_n) $rose(rewrite_en_q));
endmodule
`default_nettype wire

// >>> verif/frb_programmer_model.sv
// Behavioural model of the external flash programmer and strap wiring
`timescale 1ns/1ps
`default_nettype none
module frb_programmer_model (
   input  wire logic       clock,
   input  wire logic       boot_request,
   input  wire logic [1:0] mode_request,
   input  wire logic       erase_pulse,
   output logic            processor_mode_pin,
   output logic            boot_strap_high_pin,
   output logic            boot_strap_low_pin,
   output logic [1:0]      rewrite_mode,
   output logic            over_erased
);
   int erase_count_q = 0;

   // Straps held steady across reset; boot pattern is high, high, low
   assign processor_mode_pin  = boot_request;
   assign boot_strap_high_pin = boot_request;
   assign boot_strap_low_pin  = 1'b0;
   // Main clock stays at one fixed rate for the whole run
   assign rewrite_mode        = mode_request;

   // Counts erasures so an endurance overrun becomes visible
   always @(posedge clock) begin
      if (erase_pulse) begin
         erase_count_q <= erase_count_q + 1;
      end
   end
   assign over_erased = (erase_count_q > 100);
endmodule
`default_nettype wire

// >>> verif/test_flash_rewrite_boot_mode_control.sv
// Self-checking testbench of the flash rewrite and boot mode control block
`timescale 1ns/1ps
`default_nettype none
module test_flash_rewrite_boot_mode_control;
   logic        clock, reset_n, boot_request, ew_variant_one, memory_expansion_mode;
   logic [1:0]  mode_request, rewrite_mode;
   logic        processor_mode_pin, boot_strap_high_pin, boot_strap_low_pin, over_erased;
   logic [19:0] cpu_addr;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic        reg_write, reg_read, boot_mode, boot_rom_selected, block_a_selected;
   logic        flash_busy, program_pulse, erase_pulse;
   int          fails, total_checks;

   frb_flash_ctrl u_frb_flash_ctrl (.clock(clock), .reset_n(reset_n), .processor_mode_pin(processor_mode_pin),
      .boot_strap_high_pin(boot_strap_high_pin), .boot_strap_low_pin(boot_strap_low_pin),
      .memory_expansion_mode(memory_expansion_mode), .ew_variant_one(ew_variant_one),
      .rewrite_mode(rewrite_mode), .cpu_addr(cpu_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .boot_mode(boot_mode),
      .boot_rom_selected(boot_rom_selected), .block_a_selected(block_a_selected),
      .flash_busy(flash_busy), .program_pulse(program_pulse), .erase_pulse(erase_pulse));

   frb_programmer_model u_frb_programmer_model (.clock(clock), .boot_request(boot_request),
      .mode_request(mode_request), .erase_pulse(erase_pulse), .processor_mode_pin(processor_mode_pin),
      .boot_strap_high_pin(boot_strap_high_pin), .boot_strap_low_pin(boot_strap_low_pin),
      .rewrite_mode(rewrite_mode), .over_erased(over_erased));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // Issues a command and watches for its pulses, then for the end of busy
   task automatic op(input logic [15:0] cmd, input logic ep, input logic ee);
      logic sp, se, sb;
      sp = 1'b0;
      se = 1'b0;
      sb = 1'b0;
      wr(frb_pkg::FRB_OFS_COMMAND, cmd);
      repeat (4) begin
         @(posedge clock);
         #1;
         sp |= program_pulse;
         se |= erase_pulse;
         sb |= flash_busy;
      end
      check("program_pulse", {15'h0000, sp}, {15'h0000, ep});
      check("erase_pulse", {15'h0000, se}, {15'h0000, ee});
      check("flash_busy", {15'h0000, sb}, {15'h0000, ep | ee});
      for (int i = 0; i < 40 && flash_busy !== 1'b0; i++) @(posedge clock);
      rd(frb_pkg::FRB_OFS_FLASH_CTRL0, d);
      check("ready", d & 16'h0001, 16'h0001);
   endtask

   task automatic reset_all(input logic b, input logic [1:0] m);
      @(posedge clock);
      boot_request <= b;
      mode_request <= m;
      reset_n      <= 1'b0;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      repeat (5) @(posedge clock);
      #1;
   endtask

   task automatic t_user_start;
      reset_all(1'b0, 2'h0);
      check("boot_mode", {15'h0000, boot_mode}, 16'h0000);
      rd(frb_pkg::FRB_OFS_FLASH_CTRL0, d);
      check("ctrl0_reset", d, 16'h0001);
      rd(frb_pkg::FRB_OFS_PROC_MODE1, d);
      check("mode1_reset", d, 16'h0000);
      $display("test user_start done");
   endtask

   task automatic t_block_a;
      logic [19:0] addrs [4];
      logic        exps  [4];
      addrs = '{20'h10000, 20'h26FFF, 20'h27000, 20'h0FFFF};
      exps  = '{1'b1, 1'b1, 1'b0, 1'b0};
      wr(frb_pkg::FRB_OFS_PROC_MODE1, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         cpu_addr <= addrs[i];
         repeat (2) @(posedge clock);
         #1 check("block_a_selected", {15'h0000, block_a_selected}, {15'h0000, exps[i]});
      end
      wr(frb_pkg::FRB_OFS_PROC_MODE1, 16'h0000);
      cpu_addr <= 20'h10000;
      repeat (3) @(posedge clock);
      #1 check("block_a_disabled", {15'h0000, block_a_selected}, 16'h0000);
      $display("test block_a done");
   endtask

   task automatic t_cpu_rewrite;
      wr(frb_pkg::FRB_OFS_FLASH_CTRL0, 16'h0002);
      rd(frb_pkg::FRB_OFS_FLASH_CTRL0, d);
      check("enable_unarmed", d & 16'h0002, 16'h0000);
      op(16'h0013, 1'b0, 1'b0);
      wr(frb_pkg::FRB_OFS_STATUS, 16'h0000);
      wr(frb_pkg::FRB_OFS_FLASH_CTRL0, 16'h0000);
      wr(frb_pkg::FRB_OFS_FLASH_CTRL0, 16'h0002);
      rd(frb_pkg::FRB_OFS_FLASH_CTRL0, d);
      check("enable_armed", d & 16'h0002, 16'h0002);
      rd(frb_pkg::FRB_OFS_PROC_MODE1, d);
      check("forced_bits", d & 16'h0009, 16'h0009);
      wr(frb_pkg::FRB_OFS_PROC_MODE1, 16'h0008);
      op(16'h0013, 1'b1, 1'b0);
      op(16'h0113, 1'b0, 1'b0);
      rd(frb_pkg::FRB_OFS_FLASH_CTRL0, d);
      check("byte_refused", d & 16'h00C0, 16'h0040);
      wr(frb_pkg::FRB_OFS_STATUS, 16'h0000);
      rd(frb_pkg::FRB_OFS_FLASH_CTRL0, d);
      check("errors_cleared", d & 16'h00C0, 16'h0000);
      wr(frb_pkg::FRB_OFS_COMMAND, 16'h0026);
      repeat (30) @(posedge clock);
      rd(frb_pkg::FRB_OFS_LOCK, d);
      check("lock_bit", d & 16'h0004, 16'h0004);
      op(16'h0023, 1'b0, 1'b0);
      op(16'h0024, 1'b0, 1'b0);
      rd(frb_pkg::FRB_OFS_FLASH_CTRL0, d);
      check("locked_errors", d & 16'h00C0, 16'h00C0);
      wr(frb_pkg::FRB_OFS_STATUS, 16'h0000);
      op(16'h0014, 1'b0, 1'b1);
      op(16'h0005, 1'b0, 1'b1);
      wr(frb_pkg::FRB_OFS_FLASH_CTRL0, 16'h0000);
      rd(frb_pkg::FRB_OFS_PROC_MODE1, d);
      check("expand_restored", d & 16'h0009, 16'h0008);
      $display("test cpu_rewrite done");
   endtask

   task automatic t_boot;
      reset_all(1'b1, 2'h1);
      check("boot_mode", {15'h0000, boot_mode}, 16'h0001);
      check("boot_rom_sel", {15'h0000, boot_rom_selected}, 16'h0001);
      op(16'h0013, 1'b0, 1'b0);
      @(posedge clock);
      mode_request <= 2'h2;
      op(16'h0113, 1'b1, 1'b0);
      wr(frb_pkg::FRB_OFS_FLASH_CTRL0, 16'h0020);
      repeat (2) @(posedge clock);
      #1 check("user_rom_sel", {15'h0000, boot_rom_selected}, 16'h0000);
      @(posedge clock);
      mode_request <= 2'h1;
      op(16'h0013, 1'b1, 1'b0);
      @(posedge clock);
      mode_request <= 2'h3;
      op(16'h0014, 1'b0, 1'b1);
      reset_all(1'b0, 2'h1);
      op(16'h0013, 1'b0, 1'b0);
      wr(frb_pkg::FRB_OFS_FLASH_CTRL0, 16'h0000);
      repeat (2) @(posedge clock);
      #1 check("no_boot_sel", {15'h0000, boot_rom_selected}, 16'h0000);
      check("endurance", {15'h0000, over_erased}, 16'h0000);
      $display("test boot done");
   endtask

   initial begin
      fails = 0;
      total_checks = 0;
      reset_n = 1'b0;
      boot_request = 1'b0;
      mode_request = 2'h0;
      ew_variant_one = 1'b0;
      memory_expansion_mode = 1'b0;
      cpu_addr = 20'h00000;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      t_user_start();
      t_block_a();
      t_cpu_rewrite();
      t_boot();
      tally_and_finish();
   end

   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
